// File: design/stc_prescaler.sv
// input clock prescaler: one output tick per 1, 8, 64 or 256 input ticks
// assumes i_tick is a one-cycle pulse on the same clock
module stc_prescaler
  import stc_pkg::*;
(
  // clock and control
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  input  wire logic       i_clear,
  input  wire logic [1:0] i_select,
  // ticks
  input  wire logic       i_tick,
  output logic            o_tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] limit;
  logic       out_d;
  logic       out_q;

  always_comb begin
    unique case (stc_ps_e'(i_select))
      STC_PS_1:   limit = 8'h00;
      STC_PS_8:   limit = PS_MAX_8;
      STC_PS_64:  limit = PS_MAX_64;
      STC_PS_256: limit = PS_MAX_256;
    endcase
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (i_clear) begin
      cnt_d = 8'h00;
    end else if (i_tick) begin
      if (cnt_q >= limit) begin // R4
        cnt_d = 8'h00;
        out_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      cnt_q <= 8'h00;
      out_q <= 1'b0;
    end else if (i_clk_en) begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign o_tick = out_q;
endmodule : stc_prescaler

// File: design/stc_sync2.sv
// two-flop synchroniser for one level from outside the clock domain
// assumes the first flop feeds only the second
module stc_sync2 (
  // clock and control
  input  wire logic i_ref_clk,
  input  wire logic i_reset_n,
  input  wire logic i_clk_en,
  // level
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (i_clk_en) begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_sync = sync_q;
endmodule : stc_sync2

// File: design/stc_timer.sv
// sixteen-bit timer with run, idle halt, gate, prescale and clock source
// assumes a plain strobe register port and an asynchronous clock pin
//
// Summary of operation
// R1: counter advances only while timer_run is set; clearing it stops counting.
// R2: idle_halt set suspends the timer in idle; clear keeps it running.
// R3: gate_accumulate_en is honoured only with the internal clock selected.
// R4: prescale_select 00,01,10,11 divide the input by 1, 8, 64, 256.
// R5: ext_clock_sync picks synchronised or raw pin counting; ignored internally.
// R6: clock_source_select writes ignored while synchronised external counter runs.
// R7: clock_source_select set counts pin rising edges, clear counts instruction clock.
module stc_timer
  import stc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_clk_en,
  // register port
  input  wire logic [stc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [stc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [stc_pkg::DATA_W-1:0] o_rdata,
  // system state and pins
  input  wire logic                      i_idle,
  input  wire logic                      i_gate_pin,
  input  wire logic                      i_ext_clock_pin,
  // status
  output logic                           o_period_match
);
  import stc_pkg::*;

  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] period_q;
  logic [15:0] period_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        match_q;
  logic        match_d;
  logic        pin_sync;
  logic        gate_sync;
  logic        pin_prev_q;
  logic        raw_s1_q;
  logic        raw_s2_q;
  logic        raw_prev_q;
  logic        sync_edge;
  logic        raw_edge;
  logic        src_tick;
  logic        ps_tick;
  logic        run;
  logic        idle_halt;
  logic        gate_en;
  logic        ext_sync;
  logic        cs;
  logic        active;
  logic        ps_clear;

  assign run       = ctrl_q[BIT_RUN];
  assign idle_halt = ctrl_q[BIT_IDLE_HALT];
  assign gate_en   = ctrl_q[BIT_GATE];
  assign ext_sync  = ctrl_q[BIT_SYNC];
  assign cs        = ctrl_q[BIT_CS];

  stc_sync2 u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_async   (i_ext_clock_pin),
    .o_sync    (pin_sync)
  );

  stc_sync2 u_gate_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_async   (i_gate_pin),
    .o_sync    (gate_sync)
  );

  // unsynchronised path keeps its own flops for metastability safety;
  // its latency matches the synced path, so counts agree in both modes
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      pin_prev_q <= 1'b0;
      raw_s1_q   <= 1'b0;
      raw_s2_q   <= 1'b0;
      raw_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      pin_prev_q <= pin_sync;
      raw_s1_q   <= i_ext_clock_pin;
      raw_s2_q   <= raw_s1_q;
      raw_prev_q <= raw_s2_q;
    end
  end

  assign sync_edge = pin_sync & ~pin_prev_q;
  assign raw_edge  = raw_s2_q & ~raw_prev_q;

  always_comb begin
    if (cs) begin
      src_tick = ext_sync ? sync_edge : raw_edge; // R5 R7
    end else if (gate_en) begin
      src_tick = gate_sync; // R3
    end else begin
      src_tick = 1'b1; // R7
    end
  end

  assign active   = run && !(idle_halt && i_idle); // R1 R2
  assign ps_clear = !run;

  stc_prescaler u_prescaler (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_clk_en  (i_clk_en),
    .i_clear   (ps_clear),
    .i_select  (ctrl_q[BIT_PS_HI:BIT_PS_LO]),
    .i_tick    (src_tick && active),
    .o_tick    (ps_tick)
  );

  always_comb begin
    ctrl_d   = ctrl_q;
    count_d  = count_q;
    period_d = period_q;
    match_d  = 1'b0;
    rdata_d  = 16'h0000;
    if (ps_tick && active) begin // R1
      if (count_q == period_q) begin
        count_d = COUNT_RESET;
        match_d = 1'b1;
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
    if (i_wr) begin
      unique case (i_addr)
        ADDR_CONTROL: begin
          ctrl_d = i_wdata & CONTROL_MASK;
          if (cs && ext_sync && run) begin
            ctrl_d[BIT_CS] = cs; // R6
          end
        end
        ADDR_COUNT:  count_d  = i_wdata;
        ADDR_PERIOD: period_d = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        ADDR_CONTROL: rdata_d = ctrl_q;
        ADDR_COUNT:   rdata_d = count_q;
        ADDR_PERIOD:  rdata_d = period_q;
        default:      rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctrl_q   <= CONTROL_RESET;
      count_q  <= COUNT_RESET;
      period_q <= PERIOD_RESET;
      rdata_q  <= 16'h0000;
      match_q  <= 1'b0;
    end else if (i_clk_en) begin
      ctrl_q   <= ctrl_d;
      count_q  <= count_d;
      period_q <= period_d;
      rdata_q  <= rdata_d;
      match_q  <= match_d;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_period_match = match_q;
endmodule : stc_timer

// File: include/stc_pkg.sv
// constants for the sixteen-bit timer control block
// assumes a single 125 MHz clock and a plain strobe register port
package stc_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 16;
  localparam int          CNT_W         = 16;
  // register offsets (16-bit words)
  localparam logic [3:0]  ADDR_CONTROL  = 4'h0;
  localparam logic [3:0]  ADDR_COUNT    = 4'h1;
  localparam logic [3:0]  ADDR_PERIOD   = 4'h2;
  // control field positions
  localparam int          BIT_RUN       = 15;
  localparam int          BIT_IDLE_HALT = 13;
  localparam int          BIT_GATE      = 6;
  localparam int          BIT_PS_HI     = 5;
  localparam int          BIT_PS_LO     = 4;
  localparam int          BIT_SYNC      = 2;
  localparam int          BIT_CS        = 1;
  localparam logic [15:0] CONTROL_MASK  = 16'hA076;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
  // prescale selections
  typedef enum logic [1:0] {
    STC_PS_1   = 2'h0,
    STC_PS_8   = 2'h1,
    STC_PS_64  = 2'h2,
    STC_PS_256 = 2'h3
  } stc_ps_e;
  localparam logic [7:0]  PS_MAX_8      = 8'h07;
  localparam logic [7:0]  PS_MAX_64     = 8'h3F;
  localparam logic [7:0]  PS_MAX_256    = 8'hFF;
endpackage : stc_pkg

// File: testbench/sixteen_bit_timer_control_tb.sv
// self-checking bench for the timer control block
// assumes the pin model bursts only when asked
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end
module sixteen_bit_timer_control_tb import stc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_ref_clk = 1'b0, i_reset_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic        i_idle = 1'b0, i_gate_pin = 1'b0;
  logic        i_ext_clock_pin, o_period_match;
  logic [3:0]  i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000, o_rdata, got, g0;
  int          bad_count = 0, n_tests = 0, n;
  stc_timer uut (.i_ref_clk, .i_reset_n, .i_clk_en(1'b1), .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_idle, .i_gate_pin, .i_ext_clock_pin,
    .o_period_match);
  stc_ext_src ext (.o_pin(i_ext_clock_pin));
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    // one idle edge so back-to-back calls never retoggle the strobe
    @(posedge i_ref_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    // read data stand for the one cycle after the strobe
    @(negedge i_ref_clk);
    d = o_rdata;
    @(posedge i_ref_clk);
  endtask : rd
  task automatic near(input logic [15:0] g, input logic [15:0] e);
    `CHK(g + 16'h0003 >= e && g <= e + 16'h0003, 1'b1)
  endtask : near
  // stop, clear count, then start with the given control word
  task automatic start(input logic [15:0] c);
    wr(ADDR_CONTROL, 16'h0000);
    wr(ADDR_COUNT, 16'h0000);
    wr(ADDR_CONTROL, c);
  endtask : start
  task automatic wait_match(output int k);
    k = 0;
    do begin
      @(negedge i_ref_clk);
      k++;
    end while (o_period_match !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      stop_test;
    end
    @(posedge i_ref_clk);
  endtask : wait_match
  task automatic t_regs;
    rd(ADDR_CONTROL, got); `CHK(got, CONTROL_RESET)
    rd(ADDR_COUNT, got); `CHK(got, COUNT_RESET)
    rd(ADDR_PERIOD, got); `CHK(got, PERIOD_RESET)
    rd(4'hF, got); `CHK(got, 16'h0000)
    wr(ADDR_PERIOD, 16'h1234);
    rd(ADDR_PERIOD, got); `CHK(got, 16'h1234)
    wr(ADDR_PERIOD, 16'hFFFF);
    wr(ADDR_CONTROL, 16'hFFFF);
    rd(ADDR_CONTROL, got); `CHK(got, CONTROL_MASK)
    wr(ADDR_CONTROL, 16'h0000);
    rd(ADDR_CONTROL, got); `CHK(got, 16'h0002)
    $display("t_regs done");
  endtask : t_regs
  task automatic t_run;
    logic [15:0] ev [4] = '{16'h0200, 16'h0040, 16'h0008, 16'h0002};
    for (int p = 0; p < 4; p++) begin
      start(16'h8000 | 16'(p << 4));
      repeat (512) @(posedge i_ref_clk);
      wr(ADDR_CONTROL, 16'h0000);
      rd(ADDR_COUNT, g0);
      near(g0, ev[p]);
      repeat (20) @(posedge i_ref_clk);
      rd(ADDR_COUNT, got); `CHK(got, g0)
    end
    $display("t_run done");
  endtask : t_run
  task automatic t_idle_gate;
    i_idle <= 1'b1;
    start(16'hA000);
    repeat (20) @(posedge i_ref_clk);
    rd(ADDR_COUNT, got); `CHK(got, 16'h0000)
    start(16'h8000);
    repeat (20) @(posedge i_ref_clk);
    rd(ADDR_COUNT, got); near(got, 16'h0014);
    i_idle <= 1'b0;
    start(16'h8040);
    repeat (20) @(posedge i_ref_clk);
    rd(ADDR_COUNT, got); `CHK(got, 16'h0000)
    i_gate_pin <= 1'b1;
    repeat (16) @(posedge i_ref_clk);
    i_gate_pin <= 1'b0;
    repeat (8) @(posedge i_ref_clk);
    rd(ADDR_COUNT, got); near(got, 16'h0010);
    $display("t_idle_gate done");
  endtask : t_idle_gate
  task automatic t_ext;
    start(16'h8046);
    ext.burst(20);
    repeat (8) @(posedge i_ref_clk);
    rd(ADDR_COUNT, got); `CHK(got, 16'h0014)
    wr(ADDR_CONTROL, 16'h8044);
    rd(ADDR_CONTROL, got); `CHK(got, 16'h8046)
    start(16'h8042);
    ext.burst(20);
    repeat (8) @(posedge i_ref_clk);
    rd(ADDR_COUNT, got); `CHK(got, 16'h0014)
    $display("t_ext done");
  endtask : t_ext
  task automatic t_match;
    wr(ADDR_PERIOD, 16'h0003);
    start(16'h8000);
    wait_match(n);
    wait_match(n);
    `CHK(n, 4)
    wr(ADDR_CONTROL, 16'h0000);
    $display("t_match done");
  endtask : t_match
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial forever #4 i_ref_clk = ~i_ref_clk;
  initial begin
    repeat (6) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    @(posedge i_ref_clk);
    t_regs;
    t_run;
    t_idle_gate;
    t_ext;
    t_match;
    stop_test;
  end
endmodule : sixteen_bit_timer_control_tb

// File: testbench/stc_ext_src.sv
// clock pin source standing in front of the timer
// assumes the pin rests low between bursts
module stc_ext_src (
  output logic o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pin = 1'b0;
  // 83 ns period, unrelated in phase to the system clock
  task automatic burst(input int n);
    repeat (n) begin
      #41 o_pin = 1'b1;
      #42 o_pin = 1'b0;
    end
  endtask : burst
endmodule : stc_ext_src

// File: testbench/stc_timer_properties.sv
// port-level checks of the timer control block
// assumes i_clk_en is held high
module stc_timer_chk
  import stc_pkg::*;
(
  input wire logic                       i_ref_clk,
  input wire logic                       i_reset_n,
  input wire logic [stc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [stc_pkg::DATA_W-1:0] i_wdata,
  input wire logic                       i_wr,
  input wire logic                       i_rd,
  input wire logic [stc_pkg::DATA_W-1:0] o_rdata,
  input wire logic                       i_idle,
  input wire logic                       i_gate_pin,
  input wire logic                       o_period_match
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctrl_q, ctrl_d, per_q, per_d;
  logic [3:0]  stop_q, stop_d, hold_q, hold_d;
  logic        lock, hold;
  assign lock = ctrl_q[BIT_RUN] & ctrl_q[BIT_SYNC] & ctrl_q[BIT_CS];
  assign hold = ctrl_q[BIT_RUN] & ((i_idle & ctrl_q[BIT_IDLE_HALT]) |
                (ctrl_q[BIT_GATE] & ~ctrl_q[BIT_CS] & ~i_gate_pin));
  always_comb begin
    ctrl_d = ctrl_q;
    per_d = per_q;
    if (i_wr && i_addr == ADDR_CONTROL) begin
      ctrl_d = i_wdata & CONTROL_MASK;
      if (lock) ctrl_d[BIT_CS] = 1'b1;
    end
    if (i_wr && i_addr == ADDR_PERIOD) per_d = i_wdata;
    // saturating, so a long stop never wraps back to zero
    stop_d = ctrl_q[BIT_RUN] ? 4'h0 : stop_q + {3'h0, stop_q != 4'hF};
    hold_d = !hold ? 4'h0 : hold_q + {3'h0, hold_q != 4'hF};
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      ctrl_q <= CONTROL_RESET;
      per_q <= PERIOD_RESET;
      stop_q <= 4'h0;
      hold_q <= 4'h0;
    end else begin
      ctrl_q <= ctrl_d;
      per_q <= per_d;
      stop_q <= stop_d;
      hold_q <= hold_d;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_lock_wr;
    lock && i_wr && i_addr == ADDR_CONTROL;
  endsequence
  sequence s_ctrl_rd;
    i_rd && i_addr == ADDR_CONTROL;
  endsequence
  chk_reset_quiet: assert property ($rose(i_reset_n) |->
    o_rdata == '0 && !o_period_match) else $error("outputs not quiet");
  chk_rdata_gap: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property ($past(i_rd) &&
    $past(i_addr) > ADDR_PERIOD |-> o_rdata == '0)
    else $error("unmapped read not zero");
  chk_ctrl_read: assert property ($past(i_rd) &&
    $past(i_addr) == ADDR_CONTROL |-> o_rdata == $past(ctrl_q))
    else $error("control readback wrong");
  chk_period_read: assert property ($past(i_rd) &&
    $past(i_addr) == ADDR_PERIOD |-> o_rdata == $past(per_q))
    else $error("period readback wrong");
  chk_src_locked: assert property (s_lock_wr ##2 s_ctrl_rd |=>
    o_rdata[BIT_CS]) else $error("source changed while locked");
  chk_stop_quiet: assert property (stop_q >= 4'h8 |->
    !o_period_match) else $error("match while stopped");
  chk_hold_quiet: assert property (hold_q >= 4'h8 |->
    !o_period_match) else $error("match while held");
endmodule : stc_timer_chk
bind stc_timer stc_timer_chk chk (.i_ref_clk, .i_reset_n, .i_addr,
  .i_wdata, .i_wr, .i_rd, .o_rdata, .i_idle, .i_gate_pin, .o_period_match);
